/* sac_cmp_model.sv */
// comparator and ladder model standing beside the conversion control block
// assumes the tap code settles well before the trial ends
`timescale 1ns/1ns
module sac_cmp_model (
  input wire logic [7:0] level,
  input wire logic [7:0] tap,
  output logic above
);
  // ===========================================================
  // decision against the selected tap
  // level stands for an input half a step above its code
  // above at or past tap
  assign above = (level >= tap);
endmodule // sac_cmp_model

/* sac_conv.sv */
// successive approximation conversion control, top level
// assumes an outside comparator and ladder, and a bus that drives
// chip select, read and write start; data pins resolved outside
//
// Contract
// - msb first, eight trials, 64 clocks
// - straight binary, latch then flag low
// - new start aborts running conversion
// - select and start low set start flop
// - start falling edge clears sar and stages
// - held in reset while both low
// - conversion begins 1 to 8 clocks later
// - gated pulse clears start flop if released
// - phases run at one eighth clock
// - marker leaving last stage loads latch
// - data updated one clock before flag
// - set request lasts eight clocks
// - flag falls even with read held low
// - free running via flag looped to start
// - flag fall restarts and clears flag
// - free running flag pulse stays short
// - select and read low clear flag
// - select and read low drive data
// - select, read, start are active low
// - negative input above gives zero code
`timescale 1ns/1ns
module sac_conv (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic CMP_ABOVE,
  output logic [7:0] TAP_CODE,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  output logic CONVERSION_DONE_N
);

  // ===========================================================
  // declarations
  logic [1:0] strobe_sync;
  logic tick;
  logic wr_prev;
  logic start_flop;
  logic first_stage_flop;
  logic [7:0] stage;
  logic [7:0] sar;
  logic [3:0] set_cnt;
  logic [7:0] next_sar;
  logic [7:0] next_stage;
  logic [3:0] next_set_cnt;

  // ===========================================================
  // input synchronisation
  // strobe synchronisers
  sac_sync #(
    .WIDTH(sac_pkg::SYNC_W),
    .RST_VAL(sac_pkg::SYNC_RST)
  ) u_sync (
    .clk(SYS_CLK),
    .resetn(RESETN),
    .async_in({CS_N, WR_N}),
    .sync_out(strobe_sync)
  );

  // one phase tick per eight clocks
  sac_phase #(
    .DIV_W(sac_pkg::PHASE_W)
  ) u_phase (
    .clk(SYS_CLK),
    .resetn(RESETN),
    .tick(tick)
  );

  // ===========================================================
  // decoded controls
  wire cs_s_n = strobe_sync[1];
  wire wr_s_n = strobe_sync[0];
  wire start_set = !cs_s_n && !wr_s_n;
  wire rd_sel = !CS_N && !RD_N;
  wire wr_fell = wr_prev && !wr_s_n;
  // gated clear of the start flop
  wire start_clear_gate = tick && first_stage_flop;
  wire start_release = start_clear_gate && !start_set;
  wire converting = !start_flop && (stage != sac_pkg::STAGE_CLEAR);
  wire trial_end = tick && converting;
  wire result_transfer_gate = trial_end && stage[sac_pkg::STAGES-1];
  wire set_act = (set_cnt != sac_pkg::SET_CNT_RST);
  // start flop holds reset except on its own release tick
  // looped flag restarts through strobes
  wire conv_reset = (start_flop && !start_release) || start_set || wr_fell;

  // ===========================================================
  // trial arithmetic
  // keep trial bit only when input is above tap
  // comparator low clears only the trial bit
  wire [7:0] trial_bit = {<<{stage}};
  wire [7:0] decided = CMP_ABOVE ? sar : (sar & ~trial_bit);
  // straight binary word, msb resolved first
  wire [7:0] result_word = decided;
  wire [7:0] next_trial = {1'b0, trial_bit[7:1]};

  // next sar value
  // msb first, one trial per phase
  assign next_sar = conv_reset ? sac_pkg::RESULT_RST :
                    start_release ? sac_pkg::TRIAL_MSB :
                    trial_end ? (decided | next_trial) : sar;

  // next shift register value
  // restart clears stages mid conversion
  assign next_stage = conv_reset ? sac_pkg::STAGE_CLEAR :
                      start_release ? sac_pkg::STAGE_FIRST :
                      trial_end ? {stage[6:0], 1'b0} : stage;

  // set request countdown, loaded on the same clock as the transfer
  // eight clock set request
  assign next_set_cnt = conv_reset ? sac_pkg::SET_CNT_RST :
                        result_transfer_gate ? sac_pkg::SET_CNT_LOAD :
                        set_act ? set_cnt - 1'b1 : set_cnt;

  // ===========================================================
  // start flop and first stage
  // set start flop, load first stage
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      start_flop <= 1'b0;
      first_stage_flop <= 1'b0;
      wr_prev <= 1'b1;
    end else begin
      wr_prev <= wr_s_n;
      if (start_set) begin
        start_flop <= 1'b1;
      end else if (start_release) begin
        start_flop <= 1'b0;
      end
      if (start_release) begin
        first_stage_flop <= 1'b0;
      end else if (start_flop && tick) begin
        first_stage_flop <= 1'b1;
      end
    end
  end

  // shift register, sar and countdown
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      stage <= sac_pkg::STAGE_CLEAR;
      sar <= sac_pkg::RESULT_RST;
      set_cnt <= sac_pkg::SET_CNT_RST;
    end else begin
      stage <= next_stage;
      sar <= next_sar;
      set_cnt <= next_set_cnt;
    end
  end

  // ===========================================================
  // output latch and flag
  // data lands one clock before flag falls
  // start clears the flag in free running use
  // free running pulse ends within a few clocks
  // select and read clear the flag
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      DATA_OUT <= sac_pkg::RESULT_RST;
      CONVERSION_DONE_N <= 1'b1;
      TAP_CODE <= sac_pkg::RESULT_RST;
      DATA_OE <= 1'b0;
    end else begin
      TAP_CODE <= next_sar;
      if (result_transfer_gate) begin
        DATA_OUT <= result_word;
      end
      if (conv_reset) begin
        CONVERSION_DONE_N <= 1'b1;
      end else if (set_act) begin
        CONVERSION_DONE_N <= 1'b0;
      end else if (rd_sel) begin
        CONVERSION_DONE_N <= 1'b1;
      end
      // drivers enabled by select and read
      DATA_OE <= rd_sel;
    end
  end

  // ===========================================================
  // assertions
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESETN);

  property p_phase_rate;
    tick |=> !tick [*7] ##1 tick;
  endproperty
  a_phase_rate: assert property (p_phase_rate)
    else $error("phase tick not one in eight");

  property p_hold_reset;
    start_set |=> start_flop && (stage == 8'h00) && CONVERSION_DONE_N;
  endproperty
  a_hold_reset: assert property (p_hold_reset)
    else $error("converter not held in reset by strobes");

  property p_start_effects;
    $rose(start_flop) |=> (TAP_CODE == 8'h00) && (stage == 8'h00) && CONVERSION_DONE_N;
  endproperty
  a_start_effects: assert property (p_start_effects)
    else $error("start did not clear stages and flag");

  property p_wr_fall;
    wr_fell |=> (sar == 8'h00) && (stage == 8'h00);
  endproperty
  a_wr_fall: assert property (p_wr_fall)
    else $error("start falling edge did not clear sar");

  property p_release;
    $fell(start_flop) |-> $past(tick) && $past(first_stage_flop) && !$past(start_set);
  endproperty
  a_release: assert property (p_release)
    else $error("start flop cleared without gated pulse");

  property p_release_time;
    ($fell(start_set) && start_flop && first_stage_flop) |-> ##[0:8] !start_flop;
  endproperty
  a_release_time: assert property (p_release_time)
    else $error("conversion did not begin within eight clocks");

  property p_conv_len;
    result_transfer_gate |-> ($past(stage, 56) == 8'h01) && !$past(start_flop, 56);
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion not 64 clocks");

  property p_transfer;
    result_transfer_gate |=> (DATA_OUT == $past(result_word)) ##1 !CONVERSION_DONE_N;
  endproperty
  a_transfer: assert property (p_transfer)
    else $error("data not one clock ahead of flag");

  property p_set_hold;
    ($rose(set_act) && !start_set) ##1 !conv_reset [*7] |-> !CONVERSION_DONE_N;
  endproperty
  a_set_hold: assert property (p_set_hold)
    else $error("flag not held for set interval");

  property p_read_clear;
    (rd_sel && !set_act && !conv_reset) |=> CONVERSION_DONE_N;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("read did not clear flag");

  property p_set_wins;
    (set_act && rd_sel && !conv_reset) |=> !CONVERSION_DONE_N;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("read cleared flag during set request");

  property p_drive;
    rd_sel |=> DATA_OE;
  endproperty
  a_drive: assert property (p_drive)
    else $error("drivers not enabled by select and read");

  property p_drive_off;
    !rd_sel |=> !DATA_OE;
  endproperty
  a_drive_off: assert property (p_drive_off)
    else $error("drivers left on without select and read");

  property p_sync_lag;
    start_set |-> !$past(CS_N, 2) && !$past(WR_N, 2);
  endproperty
  a_sync_lag: assert property (p_sync_lag)
    else $error("start seen without synchroniser lag");

  property p_abort;
    (converting && start_set) |=> start_flop && (stage == 8'h00);
  endproperty
  a_abort: assert property (p_abort)
    else $error("start did not abort running conversion");

  property p_trial_keep;
    (trial_end && !conv_reset) |=> (((sar & $past(trial_bit)) != 8'h00) == $past(CMP_ABOVE));
  endproperty
  a_trial_keep: assert property (p_trial_keep)
    else $error("trial bit not kept by comparator decision");

  property p_first_msb;
    (start_release && !conv_reset) |=> (TAP_CODE == 8'h80) && (stage == 8'h01);
  endproperty
  a_first_msb: assert property (p_first_msb)
    else $error("conversion did not open with msb trial");

  property p_one_hot;
    converting |-> $onehot(stage);
  endproperty
  a_one_hot: assert property (p_one_hot)
    else $error("shift register holds more than one marker");

  property p_latch_only;
    $changed(DATA_OUT) |-> $past(result_transfer_gate);
  endproperty
  a_latch_only: assert property (p_latch_only)
    else $error("output latch changed without transfer");

  property p_flag_after;
    $fell(CONVERSION_DONE_N) |-> $past(result_transfer_gate, 2);
  endproperty
  a_flag_after: assert property (p_flag_after)
    else $error("flag fell without preceding transfer");

  property p_start_wins;
    (set_act && start_set) |=> CONVERSION_DONE_N && !set_act;
  endproperty
  a_start_wins: assert property (p_start_wins)
    else $error("start did not clear flag and set request");

  property p_stage_load;
    $rose(first_stage_flop) |-> $past(start_flop) && $past(tick);
  endproperty
  a_stage_load: assert property (p_stage_load)
    else $error("first stage loaded without start and phase");

  property p_hold_tap;
    (start_set && $past(start_set)) |-> (TAP_CODE == 8'h00) && CONVERSION_DONE_N;
  endproperty
  a_hold_tap: assert property (p_hold_tap)
    else $error("tap or flag moved while held in reset");

  c_transfer: cover property (result_transfer_gate);
  c_flag_fall: cover property ($fell(CONVERSION_DONE_N));
  c_abort: cover property (converting ##1 start_set);
  c_read_during_set: cover property (set_act && rd_sel);
  c_free_restart: cover property (set_act && start_set);

endmodule // sac_conv

/* sac_phase.sv */
// divider giving one enable pulse per internal phase
// assumes a free running system clock
`timescale 1ns/1ns
module sac_phase #(
  parameter int DIV_W = sac_pkg::PHASE_W
) (
  input wire logic clk,
  input wire logic resetn,
  output logic tick
);

  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] next_cnt;
  wire last = (cnt == sac_pkg::PHASE_LAST);

  // ===========================================================
  // wrap counter
  assign next_cnt = last ? sac_pkg::PHASE_RST : cnt + 1'b1;

  // counter and registered tick
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= sac_pkg::PHASE_RST;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= last;
    end
  end

endmodule // sac_phase

/* sac_pkg.sv */
// constants shared by the conversion control block
// assumes one 125 MHz system clock and no software registers
package sac_pkg;

  // ===========================================================
  // clock and timing
  localparam int CLK_NS = 8;                  // system clock period
  localparam int PHASE_DIV = 8;               // external clocks per internal phase
  localparam int PHASE_W = 3;                 // divider counter width
  localparam logic [2:0] PHASE_LAST = 3'h7;   // last count of a phase
  localparam logic [2:0] PHASE_RST = 3'h0;    // divider count after reset

  // ===========================================================
  // conversion sequence
  localparam int STAGES = 8;                  // shift register stages and result bits
  localparam int CONV_CYC = STAGES * PHASE_DIV; // clocks of one conversion
  localparam logic [7:0] STAGE_FIRST = 8'h01; // marker entering the first stage
  localparam logic [7:0] STAGE_CLEAR = 8'h00; // shift register cleared
  localparam logic [7:0] TRIAL_MSB = 8'h80;   // first trial code
  localparam logic [7:0] RESULT_RST = 8'h00;  // result and tap after reset
  localparam logic [7:0] FULL_SCALE = 8'hff;  // full scale code

  // ===========================================================
  // end of conversion flag
  localparam int SET_HOLD_CYC = 8;            // clocks the set request stays active
  localparam logic [3:0] SET_CNT_RST = 4'h0;
  localparam logic [3:0] SET_CNT_LOAD = 4'h8;
  localparam int FREE_PULSE_NS = 300;         // free running flag pulse, upper figure
  localparam int FREE_PULSE_CYC = FREE_PULSE_NS / CLK_NS; // rounded down

  // ===========================================================
  // synchroniser
  localparam int SYNC_W = 2;                  // chip select and write start
  localparam logic [1:0] SYNC_RST = 2'h3;     // strobes idle high

endpackage

/* sac_sync.sv */
// two flip-flop synchroniser for a group of level inputs
// assumes inputs may change at any time relative to the clock
`timescale 1ns/1ns
module sac_sync #(
  parameter int WIDTH = sac_pkg::SYNC_W,
  parameter logic [WIDTH-1:0] RST_VAL = sac_pkg::SYNC_RST
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // ===========================================================
  // two stage capture; first stage feeds only the second
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule // sac_sync

/* tb.sv */
// self-checking bench for the conversion control block
// assumes the comparator model on the ladder side and one 125 MHz clock
`timescale 1ns/1ns
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin errors++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
module tb;
  // ===========================================================
  // signals
  logic sys_clk = 1'h0;
  logic resetn = 1'h0;
  logic cs_n = 1'h1;
  logic rd_n = 1'h1;
  logic wr_drv = 1'h1;
  logic free = 1'h0;
  logic [7:0] level = 8'h00;
  logic above;
  logic [7:0] tap_code;
  logic [7:0] data_out;
  logic data_oe;
  logic done_n;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  // free running loops the flag back to write start
  wire wr_n = free ? done_n : wr_drv;

  sac_conv i_dut (.SYS_CLK(sys_clk), .RESETN(resetn), .CS_N(cs_n), .RD_N(rd_n),
    .WR_N(wr_n), .CMP_ABOVE(above), .TAP_CODE(tap_code), .DATA_OUT(data_out),
    .DATA_OE(data_oe), .CONVERSION_DONE_N(done_n));
  sac_cmp_model i_cmp (.level(level), .tap(tap_code), .above(above));

  // clock and hang limit
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      $display("CHECK FAILED %0t timeout", $time);
      close_out();
    end
  end

  // ===========================================================
  // tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic drive(logic c, logic r, logic w);
    @(posedge sys_clk);
    cs_n <= c;
    rd_n <= r;
    wr_drv <= w;
  endtask

  // one conversion; r low holds select and read through it
  task automatic conv(logic [7:0] lv, int hold, logic r);
    int n;
    int t_tap;
    logic [7:0] prev;
    level = lv;
    drive(1'h0, r, 1'h0);
    for (n = 0; n < hold; n++) begin
      tick(1);
      if (n > 3) `CHK(tap_code, 8'h00, "sar not held")
      if (n > 3) `CHK(done_n, 1'h1, "flag not cleared")
    end
    drive(r, r, 1'h1);
    t_tap = 0;
    prev = data_out;
    for (n = 1; n < 120 && done_n !== 1'h0; n++) begin
      prev = data_out;
      tick(1);
      if (t_tap == 0 && tap_code === 8'h80)
        t_tap = n;
    end
    `CHK(done_n, 1'h0, "no end flag")
    `CHK(data_out, lv, "wrong result")
    `CHK(prev, lv, "data not ahead of flag")
    `CHK(t_tap inside {[3:11]}, 1'h1, "start delay")
    `CHK((n - 1 - t_tap) inside {[64:66]}, 1'h1, "trial time")
    if (r == 1'h0) begin
      for (n = 0; n < 20 && done_n === 1'h0; n++)
        tick(1);
      `CHK(n inside {[8:9]}, 1'h1, "flag low time")
      `CHK(data_oe, 1'h1, "drivers off")
    end else begin
      tick(8);
      `CHK(done_n, 1'h0, "flag cleared early")
      drive(1'h0, 1'h0, 1'h1);
      tick(1);
      `CHK(data_oe, 1'h1, "drivers off")
      `CHK(data_out, lv, "read data")
      `CHK(done_n, 1'h1, "flag not cleared by read")
    end
    drive(1'h1, 1'h1, 1'h1);
    tick(2);
    `CHK(data_oe, 1'h0, "drivers left on")
    $display("test conversion %h done", lv);
  endtask

  // start, then restart in mid conversion
  task automatic t_abort();
    level = 8'h3c;
    drive(1'h0, 1'h1, 1'h0);
    tick(12);
    drive(1'h1, 1'h1, 1'h1);
    tick(30);
    `CHK(done_n, 1'h1, "early flag")
    `CHK(tap_code !== 8'h00, 1'h1, "not converting")
    conv(8'hc3, 12, 1'h1);
    $display("test abort done");
  endtask

  // flag looped to write start with select low
  task automatic t_free();
    logic [7:0] lv[3] = '{8'h96, 8'h69, 8'h01};
    int n;
    int w;
    level = lv[0];
    drive(1'h0, 1'h1, 1'h0);
    tick(12);
    @(posedge sys_clk);
    free <= 1'h1;
    for (int k = 0; k < 3; k++) begin
      for (n = 0; n < 150 && done_n !== 1'h0; n++)
        tick(1);
      `CHK(data_out, lv[k], "free result")
      for (w = 0; w < 40 && done_n === 1'h0; w++)
        tick(1);
      `CHK(w < sac_pkg::FREE_PULSE_CYC, 1'h1, "pulse long")
      `CHK(done_n, 1'h1, "no restart")
      if (k < 2)
        level = lv[k + 1];
    end
    @(posedge sys_clk);
    free <= 1'h0;
    wr_drv <= 1'h1;
    drive(1'h1, 1'h1, 1'h1);
    $display("test free running done");
  endtask

  // ===========================================================
  // main sequence
  initial begin
    tick(4);
    `CHK(tap_code, 8'h00, "tap reset")
    `CHK(data_out, 8'h00, "data reset")
    `CHK(data_oe, 1'h0, "enable reset")
    `CHK(done_n, 1'h1, "flag reset")
    @(posedge sys_clk);
    resetn <= 1'h1;
    conv(8'h00, 12, 1'h1);
    conv(8'hff, 12, 1'h1);
    conv(8'ha5, 40, 1'h1);
    conv(8'h5a, 12, 1'h0);
    t_abort();
    t_free();
    close_out();
  end
endmodule // tb
